// [rtl/tcc_defines.vh]
// Register map, field positions, modes and reset values of the timer block.
`ifndef TCC_DEFINES_VH
`define TCC_DEFINES_VH

// Address regions, selected by address bits 8:7.
`define TCC_RG_TMR    2'h0
`define TCC_RG_CAP    2'h1
`define TCC_RG_CMP    2'h2
`define TCC_RG_IRQ    2'h3
// Word within a unit, selected by address bits 3:2.
`define TCC_SUB_CTRL  2'h0
`define TCC_SUB_DATA  2'h1
`define TCC_SUB_PER   2'h2
`define TCC_N_UNITS   3'h5
`define TCC_BASE_A    1
`define TCC_BASE_B    2

// Timer control fields.
`define TCC_T_ON      0
`define TCC_T_EXT     1
`define TCC_T_GATE    2
`define TCC_T_PS_LO   3
`define TCC_T_PS_HI   5
`define TCC_T_CLR     6
`define TCC_T_IEN     7
`define TCC_T_PAIR    8
// Capture control fields.
`define TCC_C_RISE    0
`define TCC_C_FALL    1
`define TCC_C_SEL     2
// Compare control fields and modes.
`define TCC_O_MD_LO   0
`define TCC_O_MD_HI   2
`define TCC_O_SEL     3
`define TCC_MD_OFF    3'h0
`define TCC_MD_RISE   3'h1
`define TCC_MD_FALL   3'h2
`define TCC_MD_TOG    3'h3
`define TCC_MD_SINGLE 3'h4
`define TCC_MD_CONT   3'h5
`define TCC_MD_PWM    3'h6

// Reset values.
`define TCC_TCTRL_RST 9'h000
`define TCC_PER_RST   16'hffff
`define TCC_CCTRL_RST 3'h0
`define TCC_OCTRL_RST 4'h0
`define TCC_CMP_RST   32'h00000000
`define TCC_IRQ_RST   20'h00000

// Bus responses.
`define TCC_OKAY      2'h0
`define TCC_SLVERR    2'h2
`endif

// [rtl/tcc_timer.v]
// One timer: prescaler, clock source choice, gating and count register.
`include "tcc_defines.vh"
module tcc_timer #(
    parameter W = 16
) (
    input  wire         clk,
    input  wire         rstn,
    input  wire         enable,
    input  wire         ext_src,
    input  wire         gate_en,
    input  wire [2:0]   prescale,
    input  wire         ext_edge,
    input  wire         gate_lvl,
    input  wire         cascade,
    input  wire         casc_tick,
    input  wire         hit,
    input  wire         clr_on_hit,
    input  wire         cnt_wr,
    input  wire [W-1:0] cnt_wdata,
    output reg  [W-1:0] count,
    output wire         tick
);
    reg  [7:0] psc;
    wire [7:0] div_last;
    wire       run;
    wire       psc_done;

    // Divide ratio is two to the power of the prescale field.
    assign div_last = (8'h01 << prescale) - 8'h01;
    assign psc_done = (psc == div_last);
    // The gate pin holds the internal count while low.
    assign run = enable & (~gate_en | gate_lvl);
    // Pick the increment source: pair carry, pin edge or divided clock.
    assign tick = cascade ? casc_tick :
                  ext_src ? (enable & ext_edge) :
                  (run & psc_done);

    // Prescaler counts only while the internal source is running.
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            psc <= 8'h00;
        end else if (!run || ext_src || cascade || psc_done) begin
            psc <= 8'h00;
        end else begin
            psc <= psc + 8'h01;
        end
    end

    // Count register: software write, period restart or increment.
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            count <= {W{1'b0}};
        end else if (cnt_wr) begin
            count <= cnt_wdata;
        end else if (hit && clr_on_hit) begin
            count <= {W{1'b0}};
        end else if (tick) begin
            count <= count + {{(W-1){1'b0}}, 1'b1};
        end
    end
endmodule

// [rtl/tcc_top.v]
// Timer, capture and compare block with its register slave.
// Functional notes
// - Five timers, each sixteen bits wide.
// - Timers two+three and four+five chain to 32.
// - Count advances on bus clock or prescaled clock.
// - Period match interrupts and/or clears count.
// - Timer pin can act as external clock.
// - Gate pin level enables or holds counting.
// - Compare pin modes: PWM, pulses, toggle, edges.
// - Each compare channel picks timer two or three.
// - Capture latches selected timer on pin change.
// - Each capture channel picks timer two or three.
// - Capture edge: rising, falling or both.
// - Capture event can raise an interrupt.
// - Four-entry buffer keeps unread captures.
//
// Local design decisions: the register offsets and the AXI4-Lite register port.
`include "tcc_defines.vh"
module tcc_top #(
    parameter W     = 16,
    parameter DEPTH = 4,
    parameter PW    = 2
) (
    input  wire        clk,
    input  wire        rstn,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [8:0]  s_axi_awaddr,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    output reg  [1:0]  s_axi_bresp,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    input  wire [8:0]  s_axi_araddr,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    input  wire        timer_b_ext_clock_pin,
    input  wire        timer_e_ext_clock_pin,
    input  wire [4:0]  capture_input_pins,
    output reg  [4:0]  compare_output_pins,
    output wire        irq
);
    localparam [PW:0] FULL = DEPTH;

    reg  [8:0]     t_ctrl [0:4];
    reg  [W-1:0]   t_per [0:4];
    reg  [2:0]     ic_ctrl [0:4];
    reg  [3:0]     oc_ctrl [0:4];
    reg  [31:0]    oc_cmp [0:4];
    reg  [19:0]    irq_mask;
    reg  [19:0]    irq_stat;
    reg  [W-1:0]   cap_mem [0:5*DEPTH-1];
    reg  [PW-1:0]  cap_wp [0:4];
    reg  [PW-1:0]  cap_rp [0:4];
    reg  [PW:0]    cap_n [0:4];
    reg  [4:0]     oc_done;
    reg            aw_got;
    reg            w_got;
    reg  [8:0]     aw_a;
    reg  [31:0]    w_d;
    reg  [3:0]     w_s;
    reg  [6:0]     sync0;
    reg  [6:0]     sync1;
    reg  [6:0]     sync2;
    reg  [6:0]     flt;
    reg  [6:0]     flt_d;
    reg  [4:0]     cap_ev;
    reg  [4:0]     push;
    reg  [4:0]     pop;
    reg  [4:0]     m1;
    reg  [4:0]     m2;
    reg  [4:0]     restart;
    reg  [4:0]     cmp_ev;
    wire [5*W-1:0] cnt_all;
    wire [4:0]     tick;
    wire [4:0]     eq;
    wire [4:0]     own_hit;
    wire [4:0]     hit;
    wire [4:0]     tmr_ev;
    wire [4:0]     cnt_wr;
    wire [4:0]     casc_en;
    wire [4:0]     casc_tk;
    wire [4:0]     tpin_lvl;
    wire [4:0]     tpin_rise;
    wire [6:0]     rise;
    wire [6:0]     fall;
    wire [W-1:0]   cnt_a;
    wire [W-1:0]   cnt_b;
    wire           pair_lo;
    wire           pair_hi;
    wire           hit_lo;
    wire           hit_hi;
    wire           wr_go;
    wire           ar_go;
    wire           rd_stat;
    wire [31:0]    wr_val;
    integer        k;
    integer        c;
    integer        d;
    integer        e;

    // Checks that an address names an existing register.
    function reg_ok;
        input [8:0] a;
        begin
            case (a[8:7])
                `TCC_RG_TMR: reg_ok = (a[6:4] < `TCC_N_UNITS) && (a[3:2] <= `TCC_SUB_PER);
                `TCC_RG_CAP: reg_ok = (a[6:4] < `TCC_N_UNITS) && (a[3:2] <= `TCC_SUB_DATA);
                `TCC_RG_CMP: reg_ok = (a[6:4] < `TCC_N_UNITS) && (a[3:2] <= `TCC_SUB_DATA);
                default:     reg_ok = (a[6:4] == 3'h0) && (a[3:2] <= `TCC_SUB_DATA);
            endcase
        end
    endfunction

    // Returns the read value of the register at an address.
    function [31:0] reg_val;
        input [8:0] a;
        reg   [2:0] i;
        begin
            i = a[6:4];
            reg_val = 32'h00000000;
            if (reg_ok(a)) begin
                case (a[8:7])
                    `TCC_RG_TMR: begin
                        if (a[3:2] == `TCC_SUB_CTRL) begin
                            reg_val = {23'h000000, t_ctrl[i]};
                        end else if (a[3:2] == `TCC_SUB_DATA) begin
                            reg_val = {16'h0000, cnt_all[i*W +: W]};
                        end else begin
                            reg_val = {16'h0000, t_per[i]};
                        end
                    end
                    `TCC_RG_CAP: begin
                        if (a[3:2] == `TCC_SUB_CTRL) begin
                            reg_val = {25'h0000000, cap_n[i], 1'b0, ic_ctrl[i]};
                        end else if (cap_n[i] != 3'h0) begin
                            reg_val = {16'h0000, cap_mem[i*DEPTH + cap_rp[i]]};
                        end
                    end
                    `TCC_RG_CMP: begin
                        if (a[3:2] == `TCC_SUB_CTRL) begin
                            reg_val = {27'h0000000, compare_output_pins[i], oc_ctrl[i]};
                        end else begin
                            reg_val = oc_cmp[i];
                        end
                    end
                    default: begin
                        if (a[3:2] == `TCC_SUB_CTRL) begin
                            reg_val = {12'h000, irq_stat};
                        end else begin
                            reg_val = {12'h000, irq_mask};
                        end
                    end
                endcase
            end
        end
    endfunction

    // Merges written bytes into the old value under the byte strobes.
    function [31:0] merge;
        input [31:0] o;
        input [31:0] n;
        input [3:0]  s;
        integer      b;
        begin
            for (b = 0; b < 4; b = b + 1) begin
                merge[8*b +: 8] = s[b] ? n[8*b +: 8] : o[8*b +: 8];
            end
        end
    endfunction

    // Bus handshakes: address and data are taken in either order.
    assign s_axi_awready = ~aw_got & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_got & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    assign wr_go  = aw_got & w_got & ~s_axi_bvalid;
    assign ar_go  = s_axi_arvalid & s_axi_arready;
    assign wr_val = merge(reg_val(aw_a), w_d, w_s);
    assign rd_stat = ar_go && reg_ok(s_axi_araddr) && (s_axi_araddr[8:7] == `TCC_RG_IRQ)
                     && (s_axi_araddr[3:2] == `TCC_SUB_CTRL);

    // Channel state of the register slave.
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_a <= 9'h000;
            w_d <= 32'h00000000;
            w_s <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `TCC_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `TCC_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got <= 1'b1;
                aw_a <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got <= 1'b1;
                w_d <= s_axi_wdata;
                w_s <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_got <= 1'b0;
                w_got <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= reg_ok(aw_a) ? `TCC_OKAY : `TCC_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (ar_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= reg_val(s_axi_araddr);
                s_axi_rresp <= reg_ok(s_axi_araddr) ? `TCC_OKAY : `TCC_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Software-written configuration registers.
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (k = 0; k < 5; k = k + 1) begin
                t_ctrl[k] <= `TCC_TCTRL_RST;
                t_per[k] <= `TCC_PER_RST;
                ic_ctrl[k] <= `TCC_CCTRL_RST;
                oc_ctrl[k] <= `TCC_OCTRL_RST;
                oc_cmp[k] <= `TCC_CMP_RST;
            end
            irq_mask <= `TCC_IRQ_RST;
        end else if (wr_go && reg_ok(aw_a)) begin
            case (aw_a[8:7])
                `TCC_RG_TMR: begin
                    if (aw_a[3:2] == `TCC_SUB_CTRL) begin
                        t_ctrl[aw_a[6:4]] <= wr_val[8:0];
                    end else if (aw_a[3:2] == `TCC_SUB_PER) begin
                        t_per[aw_a[6:4]] <= wr_val[W-1:0];
                    end
                end
                `TCC_RG_CAP: begin
                    if (aw_a[3:2] == `TCC_SUB_CTRL) begin
                        ic_ctrl[aw_a[6:4]] <= wr_val[2:0];
                    end
                end
                `TCC_RG_CMP: begin
                    if (aw_a[3:2] == `TCC_SUB_CTRL) begin
                        oc_ctrl[aw_a[6:4]] <= wr_val[3:0];
                    end else begin
                        oc_cmp[aw_a[6:4]] <= wr_val;
                    end
                end
                default: begin
                    if (aw_a[3:2] == `TCC_SUB_DATA) begin
                        irq_mask <= wr_val[19:0];
                    end
                end
            endcase
        end
    end

    // Pin synchronisers; a level counts once the last two stages agree.
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync0 <= 7'h00;
            sync1 <= 7'h00;
            sync2 <= 7'h00;
            flt <= 7'h00;
            flt_d <= 7'h00;
        end else begin
            sync0 <= {timer_e_ext_clock_pin, timer_b_ext_clock_pin, capture_input_pins};
            sync1 <= sync0;
            sync2 <= sync1;
            flt <= (~(sync1 ^ sync2) & sync2) | ((sync1 ^ sync2) & flt);
            flt_d <= flt;
        end
    end
    assign rise = flt & ~flt_d;
    assign fall = ~flt & flt_d;
    assign tpin_lvl = {flt[6], 2'b00, flt[5], 1'b0};
    assign tpin_rise = {rise[6], 2'b00, rise[5], 1'b0};

    // Pairing: the upper timer steps on the lower one's wrap.
    assign pair_lo = t_ctrl[1][`TCC_T_PAIR];
    assign pair_hi = t_ctrl[3][`TCC_T_PAIR];
    assign casc_en = {pair_hi, 1'b0, pair_lo, 2'b00};
    assign casc_tk = {tick[3] & (&cnt_all[3*W +: W]), 1'b0,
                      tick[1] & (&cnt_all[W +: W]), 2'b00};
    assign own_hit = tick & eq;
    // A 32-bit match needs both halves equal on a lower step.
    assign hit_lo = tick[1] & eq[1] & eq[2];
    assign hit_hi = tick[3] & eq[3] & eq[4];
    assign hit = {pair_hi ? hit_hi : own_hit[4], pair_hi ? hit_hi : own_hit[3],
                  pair_lo ? hit_lo : own_hit[2], pair_lo ? hit_lo : own_hit[1],
                  own_hit[0]};
    assign cnt_a = cnt_all[`TCC_BASE_A*W +: W];
    assign cnt_b = cnt_all[`TCC_BASE_B*W +: W];

    // Five timers with their period comparators.
    genvar g;
    generate
        for (g = 0; g < 5; g = g + 1) begin : gen_tmr
            assign eq[g] = (cnt_all[g*W +: W] == t_per[g]);
            assign tmr_ev[g] = hit[g] & t_ctrl[g][`TCC_T_IEN];
            assign cnt_wr[g] = wr_go && reg_ok(aw_a) && (aw_a[8:7] == `TCC_RG_TMR)
                               && (aw_a[6:4] == g) && (aw_a[3:2] == `TCC_SUB_DATA);
            tcc_timer #(
                .W (W)
            ) u_tmr (
                .clk        (clk),
                .rstn       (rstn),
                .enable     (t_ctrl[g][`TCC_T_ON]),
                .ext_src    (t_ctrl[g][`TCC_T_EXT]),
                .gate_en    (t_ctrl[g][`TCC_T_GATE]),
                .prescale   (t_ctrl[g][`TCC_T_PS_HI:`TCC_T_PS_LO]),
                .ext_edge   (tpin_rise[g]),
                .gate_lvl   (tpin_lvl[g]),
                .cascade    (casc_en[g]),
                .casc_tick  (casc_tk[g]),
                .hit        (hit[g]),
                .clr_on_hit (t_ctrl[g][`TCC_T_CLR]),
                .cnt_wr     (cnt_wr[g]),
                .cnt_wdata  (wr_val[W-1:0]),
                .count      (cnt_all[g*W +: W]),
                .tick       (tick[g])
            );
        end
    endgenerate

    // Per-channel capture and compare events.
    always @* begin
        for (c = 0; c < 5; c = c + 1) begin
            cap_ev[c] = (ic_ctrl[c][`TCC_C_RISE] & rise[c])
                        | (ic_ctrl[c][`TCC_C_FALL] & fall[c]);
            push[c] = cap_ev[c] & (cap_n[c] != FULL);
            pop[c] = ar_go && reg_ok(s_axi_araddr) && (s_axi_araddr[8:7] == `TCC_RG_CAP)
                     && (s_axi_araddr[6:4] == c) && (s_axi_araddr[3:2] == `TCC_SUB_DATA)
                     && (cap_n[c] != 3'h0);
            if (oc_ctrl[c][`TCC_O_SEL]) begin
                m1[c] = tick[`TCC_BASE_B] & (cnt_b == oc_cmp[c][15:0]);
                m2[c] = tick[`TCC_BASE_B] & (cnt_b == oc_cmp[c][31:16]);
                restart[c] = hit[`TCC_BASE_B];
            end else begin
                m1[c] = tick[`TCC_BASE_A] & (cnt_a == oc_cmp[c][15:0]);
                m2[c] = tick[`TCC_BASE_A] & (cnt_a == oc_cmp[c][31:16]);
                restart[c] = hit[`TCC_BASE_A];
            end
            cmp_ev[c] = m1[c] & (oc_ctrl[c][`TCC_O_MD_HI:`TCC_O_MD_LO] != `TCC_MD_OFF);
        end
    end

    // Capture buffer storage; holds the selected timer's value.
    always @(posedge clk) begin
        for (d = 0; d < 5; d = d + 1) begin
            if (push[d]) begin
                cap_mem[d*DEPTH + cap_wp[d]] <= ic_ctrl[d][`TCC_C_SEL] ? cnt_b : cnt_a;
            end
        end
    end

    // Capture buffer pointers and fill level.
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (d = 0; d < 5; d = d + 1) begin
                cap_wp[d] <= {PW{1'b0}};
                cap_rp[d] <= {PW{1'b0}};
                cap_n[d] <= {(PW+1){1'b0}};
            end
        end else begin
            for (d = 0; d < 5; d = d + 1) begin
                cap_wp[d] <= cap_wp[d] + {{(PW-1){1'b0}}, push[d]};
                cap_rp[d] <= cap_rp[d] + {{(PW-1){1'b0}}, pop[d]};
                cap_n[d] <= cap_n[d] + {{PW{1'b0}}, push[d]} - {{PW{1'b0}}, pop[d]};
            end
        end
    end

    // Compare output pins, driven per the channel mode.
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            compare_output_pins <= 5'h00;
            oc_done <= 5'h00;
        end else begin
            for (e = 0; e < 5; e = e + 1) begin
                if (oc_ctrl[e][`TCC_O_MD_HI:`TCC_O_MD_LO] != `TCC_MD_SINGLE) begin
                    oc_done[e] <= 1'b0;
                end
                case (oc_ctrl[e][`TCC_O_MD_HI:`TCC_O_MD_LO])
                    `TCC_MD_RISE: begin
                        if (m1[e]) compare_output_pins[e] <= 1'b1;
                    end
                    `TCC_MD_FALL: begin
                        if (m1[e]) compare_output_pins[e] <= 1'b0;
                    end
                    `TCC_MD_TOG: begin
                        if (m1[e]) compare_output_pins[e] <= ~compare_output_pins[e];
                    end
                    `TCC_MD_SINGLE: begin
                        if (m1[e] && !oc_done[e]) begin
                            compare_output_pins[e] <= 1'b1;
                        end else if (m2[e] && compare_output_pins[e]) begin
                            compare_output_pins[e] <= 1'b0;
                            oc_done[e] <= 1'b1;
                        end
                    end
                    `TCC_MD_CONT: begin
                        if (m1[e]) begin
                            compare_output_pins[e] <= 1'b1;
                        end else if (m2[e]) begin
                            compare_output_pins[e] <= 1'b0;
                        end
                    end
                    `TCC_MD_PWM: begin
                        if (m1[e]) begin
                            compare_output_pins[e] <= 1'b0;
                        end else if (restart[e]) begin
                            compare_output_pins[e] <= 1'b1;
                        end
                    end
                    default: compare_output_pins[e] <= 1'b0;
                endcase
            end
        end
    end

    // Sticky status; a new event wins over the clear by read.
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_stat <= `TCC_IRQ_RST;
        end else begin
            irq_stat <= (irq_stat & ~{20{rd_stat}})
                        | {cmp_ev, cap_ev & ~push, cap_ev, tmr_ev};
        end
    end
    assign irq = |(irq_stat & irq_mask);
endmodule

// [tb/tb.sv]
// Bench of the timer block.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, rstn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0;
    logic [8:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, rv;
    logic [3:0]  s_axi_wstrb = 4'hf;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    wire         timer_b_ext_clock_pin, timer_e_ext_clock_pin;
    wire [1:0]   s_axi_bresp, s_axi_rresp;
    wire [31:0]  s_axi_rdata;
    wire [4:0]   capture_input_pins, compare_output_pins;
    int          failures = 0, comparisons = 0, hi[5], p;
    int          md[5] = '{6, 3, 4, 5, 1}, lo[5] = '{76, 90, 2, 54, 190};
    int          up[5] = '{104, 110, 4, 62, 200};
    tcc_top  tcc_top_i (.*);
    tcc_pins tcc_pins_i (.*);
    // Clock and watchdog.
    initial forever #12.5 clk = ~clk;
    initial begin
        repeat (10000) @(posedge clk);
        failures++;
        test_done;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            failures++;
            $display("BAD %0t: saw %h want %h", $time, s, e);
        end
    endtask
    // Write: both halves together, each released when taken.
    task automatic wr(input logic [8:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
        @(posedge clk);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 0;
        chk(s_axi_bresp, r);
    endtask
    // Read: address and rready up together.
    task automatic rd(input logic [8:0] a, input logic [1:0] r = 2'h0);
        @(posedge clk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 0;
        rv = s_axi_rdata;
        chk(s_axi_rresp, r);
    endtask
    task automatic test_done;
        $display("comparisons %0d, failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Test sequence.
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1;
        rd(9'h008);
        chk(rv, 32'hffff);
        rd(9'h050, 2'h2);
        chk(rv, 32'h0);
        wr(9'h050, 32'h1, 2'h2);
        wr(9'h004, 32'h12345);
        rd(9'h004);
        chk(rv, 32'h2345);
        wr(9'h004, 32'h0);
        wr(9'h000, 32'h19);
        repeat (80) @(posedge clk);
        wr(9'h000, 32'h0);
        rd(9'h004);
        chk(rv >= 9 && rv <= 12, 1);
        $display("test reset and prescale done");
        wr(9'h028, 32'h9);
        wr(9'h020, 32'hc9);
        repeat (30) @(posedge clk);
        chk(irq, 1'b0);
        wr(9'h184, 32'hfffff);
        chk(irq, 1'b1);
        wr(9'h020, 32'h0);
        rd(9'h180);
        chk(rv, 32'h4);
        chk(irq, 1'b0);
        rd(9'h024);
        chk(rv <= 9, 1);
        $display("test period done");
        wr(9'h010, 32'h3);
        wr(9'h040, 32'h3);
        tcc_pins_i.pulses(5, 7'h03);
        rd(9'h014);
        chk(rv, 32'h5);
        rd(9'h044);
        chk(rv, 32'h5);
        wr(9'h014, 32'h0);
        wr(9'h010, 32'h5);
        repeat (20) @(posedge clk);
        rd(9'h014);
        chk(rv, 32'h0);
        tcc_pins_i.gate(1'b1);
        repeat (40) @(posedge clk);
        tcc_pins_i.gate(1'b0);
        repeat (10) @(posedge clk);
        rd(9'h014);
        chk(rv >= 38 && rv <= 42, 1);
        wr(9'h040, 32'h0);
        wr(9'h044, 32'h0);
        wr(9'h034, 32'hffff);
        wr(9'h030, 32'h101);
        repeat (4) @(posedge clk);
        wr(9'h030, 32'h0);
        rd(9'h044);
        chk(rv, 32'h1);
        $display("test clock sources done");
        wr(9'h014, 32'h0);
        wr(9'h010, 32'h1);
        wr(9'h080, 32'h1);
        tcc_pins_i.pulses(5, 7'h04);
        rd(9'h080);
        chk(rv[6:4], 3'h4);
        rd(9'h180);
        chk(rv[5], 1'b1);
        chk(rv[10], 1'b1);
        for (int i = 0; i < 4; i++) begin
            rd(9'h084);
            if (i > 0) chk(rv - p, 32'd12);
            p = rv;
        end
        rd(9'h084);
        chk(rv, 32'h0);
        wr(9'h024, 32'h1234);
        for (int c = 1; c < 4; c++) wr(9'(128 + 16 * c), 32'(c + 4));
        tcc_pins_i.pulses(1, 7'h38);
        for (int c = 1; c < 4; c++) begin
            rd(9'(128 + 16 * c));
            chk(rv[6:4], 3'(c / 3 + 1));
            rd(9'(132 + 16 * c));
            chk(rv, 32'h1234);
        end
        $display("test capture done");
        wr(9'h024, 32'h0);
        foreach (md[c]) begin
            wr(9'(260 + 16 * c), 32'h0007_0004);
            wr(9'(256 + 16 * c), 32'(md[c] + 8));
        end
        hi = '{default: 0};
        wr(9'h020, 32'h41);
        repeat (200) begin
            @(posedge clk);
            foreach (hi[c]) hi[c] += compare_output_pins[c];
        end
        foreach (hi[c]) chk(hi[c] >= lo[c] && hi[c] <= up[c], 1);
        wr(9'h140, 32'ha);
        repeat (20) @(posedge clk);
        chk(compare_output_pins[4], 1'b0);
        $display("test compare done");
        test_done;
    end
endmodule

// [tb/tcc_monitor.sv]
// Checker of bus handshakes and compare pins.
module tcc_monitor (
    input wire        clk,
    input wire        rstn,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire [31:0] s_axi_rdata,
    input wire [4:0]  compare_output_pins
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // Read channel.
    a_ar_gate: assert property (s_axi_arready == !s_axi_rvalid) else $error("bad arready");
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_rd_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("rvalid repeated");
    // Write channel and compare pins at reset release.
    a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
    a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("bresp dropped");
    a_wr_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write overlap");
    a_pins_idle: assert property ($rose(rstn) |-> compare_output_pins == 5'h00)
        else $error("pins not low");
    // Scenarios.
    cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
    cover property ($rose(compare_output_pins[0]));
    cover property (s_axi_rvalid && !s_axi_rready);
endmodule
bind tcc_top tcc_monitor tcc_monitor_i (.*);

// [tb/tcc_pins.sv]
// Model of the block's clock, gate and capture pins.
module tcc_pins (
    input  wire       clk,
    output wire       timer_b_ext_clock_pin,
    output wire       timer_e_ext_clock_pin,
    output wire [4:0] capture_input_pins
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [6:0] lv = 7'h00;
    assign {capture_input_pins, timer_e_ext_clock_pin, timer_b_ext_clock_pin} = lv;
    // Pulses six cycles high, six low; long enough for the filter.
    task automatic pulses(input int n, input logic [6:0] m);
        repeat (n) begin
            @(posedge clk);
            lv <= lv | m;
            repeat (6) @(posedge clk);
            lv <= lv & ~m;
            repeat (5) @(posedge clk);
        end
    endtask
    // Gate level on the timer b pin.
    task automatic gate(input logic v);
        @(posedge clk);
        lv[0] <= v;
    endtask
endmodule
